// ### logic/iie_pkg.sv
// Package: constants and types shared by the instruction execution block
package iie_pkg;

  // Register map (byte addresses on the plain register port)
  localparam logic [7:0] OFS_CTRL      = 8'h00; // W: command, R: status
  localparam logic [7:0] OFS_INSTR     = 8'h04;
  localparam logic [7:0] OFS_OPERAND   = 8'h08;
  localparam logic [7:0] OFS_FLAGS     = 8'h0C;
  localparam logic [7:0] OFS_CTX_BASE  = 8'h10;
  localparam logic [7:0] OFS_PC        = 8'h14;
  localparam logic [7:0] OFS_WAITS     = 8'h18;
  localparam logic [7:0] OFS_EXTRA     = 8'h1C;
  localparam logic [7:0] OFS_LAST_CYC  = 8'h20;
  localparam logic [7:0] OFS_SLOT_BASE = 8'h40; // 16 context slots, one word each
  localparam logic [7:0] OFS_SLOT_MASK = 8'hC0;

  // Command and status bit positions
  localparam int unsigned CTRL_GO_BIT      = 0;
  localparam int unsigned CTRL_CLR_ERR_BIT = 1;
  localparam int unsigned STAT_BUSY_BIT    = 0;
  localparam int unsigned STAT_HALT_BIT    = 1;
  localparam int unsigned STAT_ERR_BIT     = 2;

  // Field layout of the extra-cost register
  localparam int unsigned EXTRA_CYC_LSB = 0;
  localparam int unsigned EXTRA_ACC_LSB = 8;

  // Interrupt level occupies flag bits 12..15 (MSB-first), i.e. bits 3..0 here
  localparam int unsigned IRQ_LVL_MSB = 3;

  // Reset values
  localparam logic [15:0] FLAGS_RST = 16'h0000;
  localparam logic [15:0] CTX_RST   = 16'h0000;
  localparam logic [15:0] PC_RST    = 16'h0000;
  localparam logic [3:0]  WAITS_RST = 4'h0;

  // Opcodes, bits 0..10 of the instruction word (bit 0 is the MSB)
  localparam logic [10:0] OPC_LOAD_CTX    = 11'h017;
  localparam logic [10:0] OPC_LOAD_IRQ    = 11'h018;
  localparam logic [10:0] OPC_STORE_FLAGS = 11'h016;
  localparam logic [10:0] OPC_STORE_CTX   = 11'h015;
  localparam logic [10:0] OPC_RETURN      = 11'h01C;
  localparam logic [10:0] OPC_IDLE        = 11'h01A;
  localparam logic [10:0] OPC_CLEAR_IRQ   = 11'h01B;
  localparam logic [10:0] OPC_USER_A      = 11'h01E;
  localparam logic [10:0] OPC_USER_B      = 11'h01D;
  localparam logic [10:0] OPC_USER_C      = 11'h01F;

  // Address line patterns {A13, A0, A1}
  localparam logic [2:0] LINES_IDLE   = 3'h2;
  localparam logic [2:0] LINES_CLEAR  = 3'h3;
  localparam logic [2:0] LINES_USER_A = 3'h6;
  localparam logic [2:0] LINES_USER_B = 3'h5;
  localparam logic [2:0] LINES_USER_C = 3'h7;
  localparam logic [2:0] LINES_RST    = 3'h0;

  // Base clock cycles and memory accesses, workspace-register operands
  localparam logic [7:0] CYC_LOAD_CTX = 8'h0E;
  localparam logic [7:0] ACC_LOAD_CTX = 8'h04;
  localparam logic [7:0] CYC_LOAD_IRQ = 8'h16;
  localparam logic [7:0] ACC_LOAD_IRQ = 8'h06;
  localparam logic [7:0] CYC_STORE    = 8'h08;
  localparam logic [7:0] ACC_STORE    = 8'h02;
  localparam logic [7:0] CYC_RETURN   = 8'h16;
  localparam logic [7:0] ACC_RETURN   = 8'h08;
  localparam logic [7:0] CYC_EXT      = 8'h0E;
  localparam logic [7:0] ACC_EXT      = 8'h02;

  typedef enum logic [3:0] {
    OP_NONE, OP_LOAD_CTX, OP_LOAD_IRQ, OP_STORE_FLAGS, OP_STORE_CTX, OP_RETURN,
    OP_IDLE, OP_CLEAR_IRQ, OP_USER_A, OP_USER_B, OP_USER_C
  } iie_op_e;

  typedef enum logic [1:0] {
    SEQ_READY = 2'b00,
    SEQ_RUN   = 2'b01,
    SEQ_HALT  = 2'b11
  } iie_state_e;

endpackage : iie_pkg

// ### logic/iie_cost.sv
// Execution time model: counts clock cycles plus wait states per access
module iie_cost
  import iie_pkg::*;
(
  input  wire logic        ref_clk_i,
  input  wire logic        nrst_i,
  input  wire logic        start_i,
  input  wire logic [7:0]  base_cyc_i,
  input  wire logic [7:0]  base_acc_i,
  input  wire logic [7:0]  extra_cyc_i,
  input  wire logic [7:0]  extra_acc_i,
  input  wire logic [3:0]  waits_i,
  output logic      [15:0] total_o,
  output logic             done_o
);

  logic [15:0] cnt_q;
  logic        run_q;
  logic [15:0] elapsed_q;
  logic [15:0] total_q;

  // Cycles plus wait states times accesses; widths hold the worst case
  function automatic logic [15:0] exec_total(input logic [8:0] cyc,
                                             input logic [8:0] acc,
                                             input logic [3:0] w);
    logic [15:0] prod;
    prod = 16'(w) * 16'(acc);
    return 16'(cyc) + prod;
  endfunction : exec_total

  assign total_o = exec_total(9'(base_cyc_i) + 9'(extra_cyc_i),
                              9'(base_acc_i) + 9'(extra_acc_i), waits_i);

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cnt_q <= 16'h0000;
      run_q <= 1'b0;
    end else if (start_i) begin
      cnt_q <= total_o;
      run_q <= 1'b1;
    end else if (run_q) begin
      cnt_q <= cnt_q - 16'h0001;
      run_q <= (cnt_q != 16'h0001);
    end
  end

  // Last counted cycle of the instruction
  assign done_o = run_q && (cnt_q == 16'h0001);

  // Helper for checking the length of each execution
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      elapsed_q <= 16'h0000;
      total_q   <= 16'h0000;
    end else if (start_i) begin
      elapsed_q <= 16'h0001;
      total_q   <= total_o;
    end else if (run_q) begin
      elapsed_q <= elapsed_q + 16'h0001;
    end
  end

  property p_exec_len;
    @(posedge ref_clk_i) disable iff (!nrst_i)
      done_o |-> (elapsed_q == total_q);
  endproperty
  a_exec_len: assert property (p_exec_len)
    else $error("execution length differs from cycles plus waits times accesses");

  property p_extra_cost;
    @(posedge ref_clk_i) disable iff (!nrst_i)
      start_i |=> (cnt_q == 16'(9'($past(base_cyc_i)) + 9'($past(extra_cyc_i)))
                   + 16'($past(waits_i))
                   * 16'(9'($past(base_acc_i)) + 9'($past(extra_acc_i))));
  endproperty
  a_extra_cost: assert property (p_extra_cost)
    else $error("loaded count ignores mode extras");

endmodule : iie_cost

// ### logic/iie_exec.sv
// Top: internal register and external instruction decode and execution
module iie_exec
  import iie_pkg::*;
(
  input  wire logic        ref_clk_i,
  input  wire logic        nrst_i,
  input  wire logic [7:0]  reg_addr_i,
  input  wire logic [31:0] reg_wdata_i,
  input  wire logic        reg_wr_i,
  input  wire logic        reg_rd_i,
  output logic      [31:0] reg_rdata_o,
  input  wire logic        irq_req_i,
  input  wire logic        load_req_i,
  output logic             a13_o,
  output logic             a0_o,
  output logic             a1_o,
  output logic             bit_io_strobe_o,
  output logic             busy_o,
  output logic             halted_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Decode helpers

  function automatic iie_op_e decode_op(input logic [15:0] word);
    logic [10:0] opc;
    opc = word[15:5];
    unique case (opc)
      OPC_LOAD_CTX:    return OP_LOAD_CTX;
      OPC_LOAD_IRQ:    return OP_LOAD_IRQ;
      OPC_STORE_FLAGS: return OP_STORE_FLAGS;
      OPC_STORE_CTX:   return OP_STORE_CTX;
      OPC_RETURN:      return OP_RETURN;
      OPC_IDLE:        return OP_IDLE;
      OPC_CLEAR_IRQ:   return OP_CLEAR_IRQ;
      OPC_USER_A:      return OP_USER_A;
      OPC_USER_B:      return OP_USER_B;
      OPC_USER_C:      return OP_USER_C;
      default:         return OP_NONE;
    endcase
  endfunction : decode_op

  // Line pattern of an external op; internal ops keep the lines as they were
  function automatic logic [2:0] ext_lines(input iie_op_e op, input logic [2:0] keep);
    unique case (op)
      OP_IDLE:      return LINES_IDLE;
      OP_CLEAR_IRQ: return LINES_CLEAR;
      OP_USER_A:    return LINES_USER_A;
      OP_USER_B:    return LINES_USER_B;
      OP_USER_C:    return LINES_USER_C;
      default:      return keep;
    endcase
  endfunction : ext_lines

  function automatic logic is_ext(input iie_op_e op);
    return (op == OP_IDLE) || (op == OP_CLEAR_IRQ) || (op == OP_USER_A)
        || (op == OP_USER_B) || (op == OP_USER_C);
  endfunction : is_ext

  ////////////////////////////////////////////////////////////////////////////
  // State

  iie_state_e  state_q;
  iie_op_e     op_q;
  logic [15:0] instr_q;
  logic [15:0] operand_q;
  logic [15:0] flags_word_q;
  logic [15:0] ctx_base_q;
  logic [15:0] pc_q;
  logic [3:0]  waits_q;
  logic [7:0]  extra_cyc_q;
  logic [7:0]  extra_acc_q;
  logic [15:0] last_cyc_q;
  logic        err_q;
  logic [15:0] slot_q [16];
  logic [2:0]  lines_q;
  logic [3:0]  slot_sel_q;

  logic        wr_ctrl;
  logic        go;
  logic        done;
  logic [15:0] total;
  logic [7:0]  base_cyc;
  logic [7:0]  base_acc;
  iie_op_e     new_op;

  assign wr_ctrl = reg_wr_i && (reg_addr_i == OFS_CTRL);
  assign new_op  = decode_op(instr_q);
  // A command only starts from ready; unknown codes raise the error flag instead
  assign go      = wr_ctrl && reg_wdata_i[CTRL_GO_BIT] && (state_q == SEQ_READY)
                   && (new_op != OP_NONE);

  always_comb begin
    unique case (new_op)
      OP_LOAD_CTX:                 begin base_cyc = CYC_LOAD_CTX; base_acc = ACC_LOAD_CTX; end
      OP_LOAD_IRQ:                 begin base_cyc = CYC_LOAD_IRQ; base_acc = ACC_LOAD_IRQ; end
      OP_STORE_FLAGS, OP_STORE_CTX: begin base_cyc = CYC_STORE;   base_acc = ACC_STORE;    end
      OP_RETURN:                   begin base_cyc = CYC_RETURN;   base_acc = ACC_RETURN;   end
      default:                     begin base_cyc = CYC_EXT;      base_acc = ACC_EXT;      end
    endcase
  end

  iie_cost u_cost (
    .ref_clk_i   (ref_clk_i),
    .nrst_i      (nrst_i),
    .start_i     (go),
    .base_cyc_i  (base_cyc),
    .base_acc_i  (base_acc),
    .extra_cyc_i (extra_cyc_q),
    .extra_acc_i (extra_acc_q),
    .waits_i     (waits_q),
    .total_o     (total),
    .done_o      (done)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state_q  <= SEQ_READY;
      busy_o   <= 1'b0;
      halted_o <= 1'b0;
    end else begin
      unique case (state_q)
        SEQ_READY: if (go) begin
          state_q <= SEQ_RUN;
          busy_o  <= 1'b1;
        end
        SEQ_RUN: if (done) begin
          state_q  <= (op_q == OP_IDLE) ? SEQ_HALT : SEQ_READY;
          halted_o <= (op_q == OP_IDLE);
          busy_o   <= 1'b0;
        end
        SEQ_HALT: if (irq_req_i || load_req_i) begin
          state_q  <= SEQ_READY;
          halted_o <= 1'b0;
        end
        default: begin
          state_q  <= SEQ_READY;
          busy_o   <= 1'b0;
          halted_o <= 1'b0;
        end
      endcase
    end
  end

  // Op, register field and cost are latched at start so later writes cannot disturb them
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      op_q       <= OP_NONE;
      slot_sel_q <= 4'h0;
      last_cyc_q <= 16'h0000;
    end else if (go) begin
      op_q       <= new_op;
      slot_sel_q <= instr_q[3:0];
      last_cyc_q <= total;
    end
  end

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      lines_q         <= LINES_RST;
      bit_io_strobe_o <= 1'b0;
    end else begin
      if (go) begin
        lines_q <= ext_lines(new_op, lines_q);
      end
      bit_io_strobe_o <= done && is_ext(op_q);
    end
  end

  assign a13_o = lines_q[2];
  assign a0_o  = lines_q[1];
  assign a1_o  = lines_q[0];

  ////////////////////////////////////////////////////////////////////////////
  // Registers written by software and by instruction results

  // Command inputs are frozen while an instruction runs
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      instr_q     <= 16'h0000;
      operand_q   <= 16'h0000;
      waits_q     <= WAITS_RST;
      extra_cyc_q <= 8'h00;
      extra_acc_q <= 8'h00;
    end else if (reg_wr_i && (state_q != SEQ_RUN)) begin
      if (reg_addr_i == OFS_INSTR)   instr_q   <= reg_wdata_i[15:0];
      if (reg_addr_i == OFS_OPERAND) operand_q <= reg_wdata_i[15:0];
      if (reg_addr_i == OFS_WAITS)   waits_q   <= reg_wdata_i[3:0];
      if (reg_addr_i == OFS_EXTRA) begin
        extra_cyc_q <= reg_wdata_i[EXTRA_CYC_LSB +: 8];
        extra_acc_q <= reg_wdata_i[EXTRA_ACC_LSB +: 8];
      end
    end
  end

  // Error flag: setting wins over a clear in the same write
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      err_q <= 1'b0;
    end else if (wr_ctrl && reg_wdata_i[CTRL_GO_BIT] && (state_q == SEQ_READY)
                 && (new_op == OP_NONE)) begin
      err_q <= 1'b1;
    end else if (wr_ctrl && reg_wdata_i[CTRL_CLR_ERR_BIT]) begin
      err_q <= 1'b0;
    end
  end

  // Architectural state: instruction results win over software writes
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      flags_word_q <= FLAGS_RST;
      ctx_base_q   <= CTX_RST;
      pc_q         <= PC_RST;
    end else if (done) begin
      unique case (op_q)
        OP_LOAD_CTX:  ctx_base_q <= operand_q;
        OP_LOAD_IRQ:  flags_word_q[IRQ_LVL_MSB:0] <= operand_q[IRQ_LVL_MSB:0];
        OP_RETURN: begin
          flags_word_q <= slot_q[15];
          pc_q         <= slot_q[14];
          ctx_base_q   <= slot_q[13];
        end
        OP_CLEAR_IRQ: flags_word_q[IRQ_LVL_MSB:0] <= 4'h0;
        // user ops act only on the lines
        default: ;
      endcase
    end else if (reg_wr_i && (state_q != SEQ_RUN)) begin
      if (reg_addr_i == OFS_FLAGS)    flags_word_q <= reg_wdata_i[15:0];
      if (reg_addr_i == OFS_CTX_BASE) ctx_base_q   <= reg_wdata_i[15:0];
      if (reg_addr_i == OFS_PC)       pc_q         <= reg_wdata_i[15:0];
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (done && (op_q == OP_STORE_FLAGS)) begin
      slot_q[slot_sel_q] <= flags_word_q;
    end else if (done && (op_q == OP_STORE_CTX)) begin
      slot_q[slot_sel_q] <= ctx_base_q;
    end else if (reg_wr_i && (state_q != SEQ_RUN)
                 && ((reg_addr_i & OFS_SLOT_MASK) == OFS_SLOT_BASE)) begin
      slot_q[reg_addr_i[5:2]] <= reg_wdata_i[15:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read port: data stand for one cycle after the strobe, zero otherwise

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      reg_rdata_o <= 32'h0000_0000;
    end else if (!reg_rd_i) begin
      reg_rdata_o <= 32'h0000_0000;
    end else if ((reg_addr_i & OFS_SLOT_MASK) == OFS_SLOT_BASE) begin
      reg_rdata_o <= {16'h0000, slot_q[reg_addr_i[5:2]]};
    end else begin
      unique case (reg_addr_i)
        OFS_CTRL:     reg_rdata_o <= {29'h0, err_q, halted_o, busy_o};
        OFS_INSTR:    reg_rdata_o <= {16'h0000, instr_q};
        OFS_OPERAND:  reg_rdata_o <= {16'h0000, operand_q};
        OFS_FLAGS:    reg_rdata_o <= {16'h0000, flags_word_q};
        OFS_CTX_BASE: reg_rdata_o <= {16'h0000, ctx_base_q};
        OFS_PC:       reg_rdata_o <= {16'h0000, pc_q};
        OFS_WAITS:    reg_rdata_o <= {28'h0000000, waits_q};
        OFS_EXTRA:    reg_rdata_o <= {16'h0000, extra_acc_q, extra_cyc_q};
        OFS_LAST_CYC: reg_rdata_o <= {16'h0000, last_cyc_q};
        default:      reg_rdata_o <= 32'h0000_0000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!nrst_i);

  sequence s_commit(iie_op_e op);
    done && (op_q == op);
  endsequence

  property p_load_ctx;
    s_commit(OP_LOAD_CTX) |=> (ctx_base_q == $past(operand_q)) && $stable(flags_word_q);
  endproperty
  a_load_ctx: assert property (p_load_ctx)
    else $error("context base not loaded from operand");

  property p_irq_level;
    s_commit(OP_LOAD_IRQ) |=> (flags_word_q[3:0] == $past(operand_q[3:0]))
                             && $stable(flags_word_q[15:4]);
  endproperty
  a_irq_level: assert property (p_irq_level)
    else $error("irq level not loaded from operand");

  property p_store;
    s_commit(OP_STORE_FLAGS) |=> (slot_q[$past(slot_sel_q)] == $past(flags_word_q))
                                && $stable(flags_word_q);
  endproperty
  a_store: assert property (p_store)
    else $error("flags word not stored into slot");

  property p_return;
    s_commit(OP_RETURN) |=> (flags_word_q == $past(slot_q[15])) && (pc_q == $past(slot_q[14]))
                           && (ctx_base_q == $past(slot_q[13]));
  endproperty
  a_return: assert property (p_return)
    else $error("context return loaded wrong slots");

  property p_strobe;
    bit_io_strobe_o |-> ({a13_o, a0_o, a1_o} == ext_lines(op_q, 3'h0)) && $stable(lines_q)
                        ##1 !bit_io_strobe_o;
  endproperty
  a_strobe: assert property (p_strobe)
    else $error("strobe without its line pattern or longer than one cycle");

  property p_idle_halt;
    s_commit(OP_IDLE) |=> halted_o && !busy_o && (state_q == SEQ_HALT);
  endproperty
  a_idle_halt: assert property (p_idle_halt)
    else $error("idle did not halt");

  property p_halt_stay;
    halted_o && !irq_req_i && !load_req_i |=> halted_o && (state_q == SEQ_HALT);
  endproperty
  a_halt_stay: assert property (p_halt_stay)
    else $error("halt left without wake request");

  property p_clear;
    s_commit(OP_CLEAR_IRQ) |=> (flags_word_q[3:0] == 4'h0) && bit_io_strobe_o
                              && ({a13_o, a0_o, a1_o} == LINES_CLEAR);
  endproperty
  a_clear: assert property (p_clear)
    else $error("external clear failed");

  property p_user;
    (s_commit(OP_USER_A) or s_commit(OP_USER_B) or s_commit(OP_USER_C))
      |=> $stable(flags_word_q) && $stable(ctx_base_q) && $stable(pc_q) && bit_io_strobe_o;
  endproperty
  a_user: assert property (p_user)
    else $error("user op changed state or missed strobe");

endmodule : iie_exec

// ### verification/iie_ctl_model.sv
// Model of the outside control logic that decodes the three lines on each strobe
module iie_ctl_model (
  input  wire logic       ref_clk_i,
  input  wire logic       nrst_i,
  input  wire logic       a13_i,
  input  wire logic       a0_i,
  input  wire logic       a1_i,
  input  wire logic       strobe_i,
  output logic      [2:0] code_o,
  output logic      [7:0] count_o
);
  timeunit 1ns;
  timeprecision 1ps;

  // sample on strobe
  // Lines are trusted only at the strobe edge; between strobes they may show stale codes
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      code_o  <= 3'h0;
      count_o <= 8'h00;
    end else if (strobe_i) begin
      code_o  <= {a13_i, a0_i, a1_i};
      count_o <= count_o + 8'h01; // One started function per pulse
    end
  end
endmodule : iie_ctl_model

// ### verification/tb.sv
// Testbench for the instruction execution block with the control logic model
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import iie_pkg::*;

  logic        ref_clk_i, nrst_i, reg_wr_i, reg_rd_i, irq_req_i, load_req_i;
  logic        a13_o, a0_o, a1_o, bit_io_strobe_o, busy_o, halted_o;
  logic [7:0]  reg_addr_i, cnt;
  logic [31:0] reg_wdata_i, reg_rdata_o;
  logic [2:0]  code;
  int          err_total = 0;
  int          tests_run = 0;
  int          cyc = 0;

  iie_exec u_dut (
    .ref_clk_i(ref_clk_i),
    .nrst_i(nrst_i),
    .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i),
    .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o),
    .irq_req_i(irq_req_i),
    .load_req_i(load_req_i),
    .a13_o(a13_o),
    .a0_o(a0_o),
    .a1_o(a1_o),
    .bit_io_strobe_o(bit_io_strobe_o),
    .busy_o(busy_o),
    .halted_o(halted_o)
  );

  iie_ctl_model u_ctl (
    .ref_clk_i(ref_clk_i),
    .nrst_i(nrst_i),
    .a13_i(a13_o),
    .a0_i(a0_o),
    .a1_i(a1_o),
    .strobe_i(bit_io_strobe_o),
    .code_o(code),
    .count_o(cnt)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Compare and count
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // One-cycle write; the trailing gap avoids a double assignment at one edge
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge ref_clk_i);
    reg_addr_i  <= a;
    reg_wdata_i <= {16'h0000, d};
    reg_wr_i    <= 1'b1;
    @(posedge ref_clk_i);
    reg_wr_i    <= 1'b0;
  endtask : wr

  // Read and compare in the single cycle where the data stand
  task automatic rdc(input logic [7:0] a, input logic [15:0] exp);
    @(posedge ref_clk_i);
    reg_addr_i <= a;
    reg_rd_i   <= 1'b1;
    @(posedge ref_clk_i);
    reg_rd_i   <= 1'b0;
    #1 check(reg_rdata_o, {16'h0000, exp});
  endtask : rdc

  // Start one op, count busy cycles, then compare duration and strobe count
  task automatic exec(input logic [10:0] op, input logic [3:0] n, input int t,
                      input logic [7:0] s);
    int         k;
    logic [7:0] c0;
    k = 0;
    c0 = cnt;
    wr(OFS_INSTR, {op, 1'b0, n});
    wr(OFS_CTRL, 16'h0001);
    #1;
    for (int i = 0; i < 2000 && (k == 0 || busy_o === 1'b1); i++) begin
      if (busy_o === 1'b1) k++;
      @(posedge ref_clk_i);
      #1;
    end
    @(posedge ref_clk_i);
    #1 check(32'(k), 32'(t));
    check({24'h000000, cnt - c0}, {24'h000000, s});
  endtask : exec

  task automatic t_load();
    rdc(8'h30, 16'h0000);
    wr(OFS_FLAGS, 16'hA5A5);
    wr(OFS_OPERAND, 16'hBEEF);
    exec(11'b00000010111, 4'h0, 14, 8'h00);
    rdc(OFS_CTX_BASE, 16'hBEEF);
    rdc(OFS_FLAGS, 16'hA5A5);
    // Two waits, three extra cycles and one extra access: 25 + 2 * 7
    wr(OFS_WAITS, 16'h0002);
    wr(OFS_EXTRA, 16'h0103);
    wr(OFS_OPERAND, 16'hFFF3);
    exec(11'b00000011000, 4'h0, 39, 8'h00);
    rdc(OFS_LAST_CYC, 16'h0027);
    rdc(OFS_FLAGS, 16'hA5A3);
    wr(OFS_WAITS, 16'h0000);
    wr(OFS_EXTRA, 16'h0000);
    $display("test load done");
  endtask : t_load

  task automatic t_store();
    exec(11'b00000010110, 4'h5, 8, 8'h00);
    rdc(OFS_SLOT_BASE + 8'h14, 16'hA5A3);
    exec(11'b00000010101, 4'h9, 8, 8'h00);
    rdc(OFS_SLOT_BASE + 8'h24, 16'hBEEF);
    rdc(OFS_FLAGS, 16'hA5A3);
    $display("test store done");
  endtask : t_store

  task automatic t_return();
    wr(OFS_SLOT_BASE + 8'h34, 16'h0C0D);
    wr(OFS_SLOT_BASE + 8'h38, 16'h0E0E);
    wr(OFS_SLOT_BASE + 8'h3C, 16'h0F0F);
    exec(11'b00000011100, 4'h0, 22, 8'h00);
    rdc(OFS_FLAGS, 16'h0F0F);
    rdc(OFS_PC, 16'h0E0E);
    rdc(OFS_CTX_BASE, 16'h0C0D);
    $display("test return done");
  endtask : t_return

  // Clear op first, then the three user ops that must leave the flags alone
  task automatic t_ext();
    logic [10:0] ops [4];
    logic [2:0]  lns [4];
    ops = '{11'b00000011011, 11'b00000011110, 11'b00000011101, 11'b00000011111};
    lns = '{3'b011, 3'b110, 3'b101, 3'b111};
    for (int i = 0; i < 4; i++) begin
      wr(OFS_FLAGS, 16'h0F09);
      exec(ops[i], 4'h0, 14, 8'h01);
      check({29'h00000000, code}, {29'h00000000, lns[i]});
      rdc(OFS_FLAGS, (i == 0) ? 16'h0F00 : 16'h0F09);
    end
    $display("test external done");
  endtask : t_ext

  // Unknown opcode must not start anything; it raises the error bit until cleared
  task automatic t_err();
    wr(OFS_INSTR, 16'h0000);
    wr(OFS_CTRL, 16'h0001);
    #1 check({31'h00000000, busy_o}, 32'h00000000);
    rdc(OFS_CTRL, 16'h0004);
    wr(OFS_CTRL, 16'h0002);
    rdc(OFS_CTRL, 16'h0000);
    $display("test error done");
  endtask : t_err

  // Idle halts, refuses a start, and wakes on the chosen request line
  task automatic t_idle(input logic wake_irq);
    exec(11'b00000011010, 4'h0, 14, 8'h01);
    check({29'h00000000, code}, 32'h00000002);
    rdc(OFS_CTRL, 16'h0002);
    wr(OFS_CTRL, 16'h0001);
    repeat (3) @(posedge ref_clk_i);
    #1 check({30'h00000000, busy_o, halted_o}, 32'h00000001);
    @(posedge ref_clk_i);
    irq_req_i  <= wake_irq;
    load_req_i <= ~wake_irq;
    @(posedge ref_clk_i);
    irq_req_i  <= 1'b0;
    load_req_i <= 1'b0;
    repeat (2) @(posedge ref_clk_i);
    #1 check({31'h00000000, halted_o}, 32'h00000000);
    $display("test idle done");
  endtask : t_idle

  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : finish_test

  ////////////////////////////////////////////////////////////////////////////
  // Clock at 50 ns period
  initial begin
    ref_clk_i = 1'b0;
    forever #25 ref_clk_i = ~ref_clk_i;
  end

  // Hang guard; the whole run needs well under a thousand cycles
  always @(posedge ref_clk_i) begin
    cyc++;
    if (cyc == 5000) begin
      err_total++;
      finish_test();
    end
  end

  // Main sequence
  initial begin
    nrst_i      = 1'b0;
    reg_addr_i  = 8'h00;
    reg_wdata_i = 32'h00000000;
    reg_wr_i    = 1'b0;
    reg_rd_i    = 1'b0;
    irq_req_i   = 1'b0;
    load_req_i  = 1'b0;
    repeat (16) @(posedge ref_clk_i);
    nrst_i <= 1'b1;
    t_load();
    t_store();
    t_return();
    t_ext();
    t_err();
    t_idle(1'b1);
    t_idle(1'b0);
    finish_test();
  end
endmodule : tb
